// ==== src/dpcd_pkg.sv ====
// Constants and types shared by the potentiometer command decoder
package dpcd_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned WIPER_SETTLE_NS = 1000;
    localparam int unsigned NV_WRITE_MS = 10;
    localparam int unsigned SETTLE_W = 8;
    localparam int unsigned NV_CNT_W = 21;
    // Least delay: round up
    localparam logic [SETTLE_W-1:0] SETTLE_CYCLES =
        SETTLE_W'((WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Longest time: round down
    localparam int unsigned NV_WRITE_CYCLES = (NV_WRITE_MS * 1000000) / CLK_PERIOD_NS;

    // Device type identifier, arbitrary value
    localparam logic [3:0] TYPE_ID = 4'hA;

    // Instruction byte layout
    localparam int unsigned OPC_MSB = 7;
    localparam int unsigned OPC_LSB = 4;
    localparam int unsigned SEL_MSB = 3;
    localparam int unsigned SEL_LSB = 2;

    // Operation codes
    localparam logic [3:0] OPC_RD_WIPER = 4'h9;
    localparam logic [3:0] OPC_WR_WIPER = 4'hA;
    localparam logic [3:0] OPC_RD_SET = 4'hB;
    localparam logic [3:0] OPC_WR_SET = 4'hC;
    localparam logic [3:0] OPC_SET_TO_WIPER = 4'hD;
    localparam logic [3:0] OPC_WIPER_TO_SET = 4'hE;
    localparam logic [3:0] OPC_STEP = 4'h2;

    // Values after reset, wiper limits and bits per byte
    localparam logic [5:0] WIPER_RESET = 6'h00;
    localparam logic [5:0] SETTING_RESET = 6'h00;
    localparam logic [5:0] WIPER_MAX = 6'h3F;
    localparam logic [5:0] WIPER_MIN = 6'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_PWRUP,
        ST_IDLE,
        ST_ADDR,
        ST_INSTR,
        ST_DATA_RX,
        ST_DATA_TX,
        ST_STEP,
        ST_IGNORE
    } dpcd_state_t;

endpackage : dpcd_pkg

// ==== src/dpcd_decoder.sv ====
// Two-wire command decoder, wiper register and setting store for one potentiometer
//
// Contract
// (R01) Upper instruction nibble selects the operation
// (R02) Next two bits pick setting register
// (R03) 1001 returns wiper position in data byte
// (R04) 1100 writes data byte into setting register
// (R05) 1101 copies setting register into wiper
// (R06) 1110 copies wiper into setting register
// (R07) 0010 enters wiper step mode
// (R08) Transfers end after acknowledged instruction byte
// (R09) Tap output follows wiper after settle delay
// (R10) Wiper-to-setting write lasts the write time
// (R11) Reads and writes use one data byte
// (R12) SDA high pulse steps wiper up
// (R13) SDA low pulse steps wiper down
// (R14) Six-bit wiper decodes to one tap
// (R15) Power-up loads wiper from setting zero
// (R16) Wiper keeps nothing across power loss
// (R17) Setting writes finish within ten milliseconds
// (R18) Four six-bit setting registers are kept
// (R19) Filler bits are ignored
// (R20) Acknowledge address, instruction and written data
// (R21) 1010 writes data byte into wiper
// (R22) Data value in low six bits
// (R23) Write-protect low blocks setting writes
// (R24) No address acknowledge while write busy
// (R25) 1011 returns selected setting register
// (R26) Steps saturate; stop ends step mode
`timescale 1ns/1ps
`default_nettype none

module dpcd_decoder #(
    parameter int unsigned NV_WRITE_CYCLES = dpcd_pkg::NV_WRITE_CYCLES
) (
    input wire logic clk,                 // System clock, 125 MHz
    input wire logic nrst,                // Asynchronous reset, active low
    input wire logic clkEn,               // Freezes all state while low
    input wire logic sclPin,              // Serial clock pin
    input wire logic sdaIn,               // Serial data pin level
    output logic sdaOut,                  // Serial data drive value, always low
    output logic sdaOe,                   // Pulls serial data low while high
    input wire logic writeProtectN,       // Blocks setting writes while low
    input wire logic [3:0] deviceSelect,  // Device select straps
    output logic [5:0] wiperValue,        // Settled wiper position
    output logic [63:0] wiperTap,         // One-hot tap switch enables
    output logic nvBusy,                  // Setting write in progress
    output logic stepActive               // Step mode engaged
);

    typedef struct packed {
        logic sclMeta;
        logic sclSync;
        logic sclLast;
        logic sdaMeta;
        logic sdaSync;
        logic sdaLast;
        logic wpMeta;
        logic wpSync;
        logic [3:0] devMeta;
        logic [3:0] devSync;
        dpcd_pkg::dpcd_state_t state;
        dpcd_pkg::dpcd_state_t follow;
        logic [3:0] bitCnt;
        logic ackPhase;
        logic [7:0] shiftReg;
        logic [7:0] txByte;
        logic [3:0] opcode;
        logic [1:0] sel;
        logic sdaDrive;
        logic [5:0] wiper;
        logic [5:0] tapPos;
        logic [dpcd_pkg::SETTLE_W-1:0] settleCnt;
        logic [3:0][5:0] setting;
        logic nvPending;
        logic [1:0] nvSel;
        logic [5:0] nvData;
        logic nvBusy;
        logic [dpcd_pkg::NV_CNT_W-1:0] nvCnt;
    } dpcd_regs_t;

    localparam logic [dpcd_pkg::NV_CNT_W-1:0] NV_LOAD = dpcd_pkg::NV_CNT_W'(NV_WRITE_CYCLES);

    function automatic logic [63:0] tap_decode(input logic [5:0] pos);
        tap_decode = 64'h1 << pos;
    endfunction : tap_decode

    dpcd_regs_t st;
    dpcd_regs_t next_st;
    logic rstMeta;
    logic rstN;
    logic sclRise;
    logic sclFall;
    logic busStart;
    logic busStop;

    // Reset release passes two flops so every state flop leaves reset together
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else if (clkEn) begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    assign sclRise = st.sclSync && !st.sclLast;
    assign sclFall = !st.sclSync && st.sclLast;
    // Start and stop are data edges while the clock stays high
    assign busStart = st.sclSync && st.sclLast && st.sdaLast && !st.sdaSync;
    assign busStop = st.sclSync && st.sclLast && !st.sdaLast && st.sdaSync;

    always_comb begin
        next_st = st;
        next_st.sclMeta = sclPin;
        next_st.sclSync = st.sclMeta;
        next_st.sclLast = st.sclSync;
        next_st.sdaMeta = sdaIn;
        next_st.sdaSync = st.sdaMeta;
        next_st.sdaLast = st.sdaSync;
        next_st.wpMeta = writeProtectN;
        next_st.wpSync = st.wpMeta;
        next_st.devMeta = deviceSelect;
        next_st.devSync = st.devMeta;

        // (R09) settle delay
        if (st.settleCnt != '0) begin
            next_st.settleCnt = st.settleCnt - 1'b1;
        end
        if (st.settleCnt == dpcd_pkg::SETTLE_W'(1)) begin
            next_st.tapPos = st.wiper;
        end

        // (R10) (R17) write time
        if (st.nvBusy) begin
            if (st.nvCnt <= dpcd_pkg::NV_CNT_W'(1)) begin
                next_st.setting[st.nvSel] = st.nvData;
                next_st.nvBusy = 1'b0;
                next_st.nvCnt = '0;
            end else begin
                next_st.nvCnt = st.nvCnt - 1'b1;
            end
        end

        if (st.state == dpcd_pkg::ST_PWRUP) begin
            // (R15) power-up recall
            next_st.wiper = st.setting[0];
            next_st.state = dpcd_pkg::ST_IDLE;
        end else if (busStart) begin
            next_st.state = dpcd_pkg::ST_ADDR;
            next_st.bitCnt = '0;
            next_st.ackPhase = 1'b0;
            next_st.sdaDrive = 1'b0;
            next_st.nvPending = 1'b0;
        end else if (busStop) begin
            // (R26) stop ends stepping
            next_st.state = dpcd_pkg::ST_IDLE;
            next_st.ackPhase = 1'b0;
            next_st.sdaDrive = 1'b0;
            next_st.nvPending = 1'b0;
            // (R23) checked again at launch
            if (st.nvPending && st.wpSync && !st.nvBusy) begin
                next_st.nvBusy = 1'b1;
                next_st.nvCnt = NV_LOAD;
            end
        end else if (sclRise) begin
            case (st.state)
                dpcd_pkg::ST_ADDR, dpcd_pkg::ST_INSTR, dpcd_pkg::ST_DATA_RX: begin
                    if (!st.ackPhase && st.bitCnt < dpcd_pkg::BITS_PER_BYTE) begin
                        next_st.shiftReg = {st.shiftReg[6:0], st.sdaSync};
                        next_st.bitCnt = st.bitCnt + 1'b1;
                    end
                end
                dpcd_pkg::ST_DATA_TX: begin
                    if (!st.ackPhase && st.bitCnt < dpcd_pkg::BITS_PER_BYTE) begin
                        next_st.bitCnt = st.bitCnt + 1'b1;
                    end
                end
                dpcd_pkg::ST_STEP: begin
                    // (R12) (R13) (R26) saturating steps
                    if (st.sdaSync) begin
                        if (st.wiper != dpcd_pkg::WIPER_MAX) begin
                            next_st.wiper = st.wiper + 1'b1;
                        end
                    end else if (st.wiper != dpcd_pkg::WIPER_MIN) begin
                        next_st.wiper = st.wiper - 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (st.state)
                dpcd_pkg::ST_ADDR, dpcd_pkg::ST_INSTR, dpcd_pkg::ST_DATA_RX, dpcd_pkg::ST_DATA_TX: begin
                    if (st.ackPhase) begin
                        // Ack slot over: release, or drive first read bit, and move on
                        next_st.ackPhase = 1'b0;
                        next_st.bitCnt = '0;
                        next_st.state = st.follow;
                        next_st.sdaDrive = (st.follow == dpcd_pkg::ST_DATA_TX) ? ~st.txByte[7] : 1'b0;
                    end else if (st.bitCnt == dpcd_pkg::BITS_PER_BYTE) begin
                        next_st.ackPhase = 1'b1;
                        next_st.sdaDrive = 1'b0;
                        next_st.follow = dpcd_pkg::ST_IGNORE;
                        case (st.state)
                            dpcd_pkg::ST_ADDR: begin
                                // (R24) silent while busy
                                if (st.shiftReg == {dpcd_pkg::TYPE_ID, st.devSync} && !st.nvBusy) begin
                                    // (R20) address ack
                                    next_st.sdaDrive = 1'b1;
                                    next_st.follow = dpcd_pkg::ST_INSTR;
                                end
                            end
                            dpcd_pkg::ST_INSTR: begin
                                // (R01) (R02) (R19) field split
                                next_st.opcode = st.shiftReg[dpcd_pkg::OPC_MSB:dpcd_pkg::OPC_LSB];
                                next_st.sel = st.shiftReg[dpcd_pkg::SEL_MSB:dpcd_pkg::SEL_LSB];
                                next_st.sdaDrive = 1'b1;
                                case (st.shiftReg[dpcd_pkg::OPC_MSB:dpcd_pkg::OPC_LSB])
                                    dpcd_pkg::OPC_RD_WIPER: begin
                                        // (R03) (R22) wiper readback
                                        next_st.txByte = {2'h0, st.wiper};
                                        next_st.follow = dpcd_pkg::ST_DATA_TX;
                                    end
                                    dpcd_pkg::OPC_RD_SET: begin
                                        // (R25) setting readback
                                        next_st.txByte = {2'h0, st.setting[st.shiftReg[dpcd_pkg::SEL_MSB:dpcd_pkg::SEL_LSB]]};
                                        next_st.follow = dpcd_pkg::ST_DATA_TX;
                                    end
                                    dpcd_pkg::OPC_WR_WIPER, dpcd_pkg::OPC_WR_SET: begin
                                        // (R11) one data byte follows
                                        next_st.follow = dpcd_pkg::ST_DATA_RX;
                                    end
                                    dpcd_pkg::OPC_SET_TO_WIPER: begin
                                        // (R05) (R08) parallel load, no data byte
                                        next_st.wiper = st.setting[st.shiftReg[dpcd_pkg::SEL_MSB:dpcd_pkg::SEL_LSB]];
                                    end
                                    dpcd_pkg::OPC_WIPER_TO_SET: begin
                                        // (R06) (R08) (R23) store queued for stop
                                        next_st.nvPending = st.wpSync;
                                        next_st.nvSel = st.shiftReg[dpcd_pkg::SEL_MSB:dpcd_pkg::SEL_LSB];
                                        next_st.nvData = st.wiper;
                                    end
                                    dpcd_pkg::OPC_STEP: begin
                                        // (R07) step mode
                                        next_st.follow = dpcd_pkg::ST_STEP;
                                    end
                                    default: begin
                                        // Unknown codes get no ack
                                        next_st.sdaDrive = 1'b0;
                                    end
                                endcase
                            end
                            dpcd_pkg::ST_DATA_RX: begin
                                // (R20) data ack
                                next_st.sdaDrive = 1'b1;
                                if (st.opcode == dpcd_pkg::OPC_WR_WIPER) begin
                                    // (R21) (R22) direct wiper write
                                    next_st.wiper = st.shiftReg[5:0];
                                end else begin
                                    // (R04) (R23) setting write queued
                                    next_st.nvPending = st.wpSync;
                                    next_st.nvSel = st.sel;
                                    next_st.nvData = st.shiftReg[5:0];
                                end
                            end
                            default: begin
                                // Read byte done: release for master ack
                            end
                        endcase
                    end else if (st.state == dpcd_pkg::ST_DATA_TX) begin
                        next_st.sdaDrive = ~st.txByte[3'(4'h7 - st.bitCnt)];
                    end
                end
                default: begin
                end
            endcase
        end

        // (R09) any wiper change restarts settle
        if (next_st.wiper != st.wiper) begin
            next_st.settleCnt = dpcd_pkg::SETTLE_CYCLES;
        end
    end

    // (R16) (R18) wiper and four settings cleared by reset
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= '{
                state: dpcd_pkg::ST_PWRUP,
                follow: dpcd_pkg::ST_IGNORE,
                wiper: dpcd_pkg::WIPER_RESET,
                tapPos: dpcd_pkg::WIPER_RESET,
                setting: {4{dpcd_pkg::SETTING_RESET}},
                sclMeta: 1'b1,
                sclSync: 1'b1,
                sclLast: 1'b1,
                sdaMeta: 1'b1,
                sdaSync: 1'b1,
                sdaLast: 1'b1,
                default: '0
            };
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = st.sdaDrive;
    assign wiperValue = st.tapPos;
    // (R14) one tap enabled
    assign wiperTap = tap_decode(st.tapPos);
    assign nvBusy = st.nvBusy;
    assign stepActive = (st.state == dpcd_pkg::ST_STEP);

    default clocking @(posedge clk); endclocking
    default disable iff (!rstN);

    chk_tap_onehot: // (R14)
        assert property ($onehot(wiperTap)) else $error("tap enable is not one-hot");

    chk_busy_noack: // (R24)
        assert property (st.nvBusy && st.state == dpcd_pkg::ST_ADDR && st.ackPhase |-> !sdaOe)
        else $error("address acknowledged during a setting write");

    chk_wp_block: // (R23)
        assert property (clkEn && !st.nvBusy ##1 st.nvBusy |-> $past(st.wpSync))
        else $error("setting write launched while write-protected");

    chk_step_up: // (R12)
        assert property (clkEn && st.state == dpcd_pkg::ST_STEP && sclRise && !busStart && !busStop
            && st.sdaSync && st.wiper != dpcd_pkg::WIPER_MAX |=> st.wiper == $past(st.wiper) + 6'h01)
        else $error("step up did not add one");

    chk_step_down: // (R13)
        assert property (clkEn && st.state == dpcd_pkg::ST_STEP && sclRise && !busStart && !busStop
            && !st.sdaSync && st.wiper != dpcd_pkg::WIPER_MIN |=> st.wiper == $past(st.wiper) - 6'h01)
        else $error("step down did not subtract one");

    chk_step_sat: // (R26)
        assert property (clkEn && st.state == dpcd_pkg::ST_STEP && sclRise
            && st.sdaSync && st.wiper == dpcd_pkg::WIPER_MAX |=> st.wiper == dpcd_pkg::WIPER_MAX)
        else $error("wiper wrapped past the top");

    chk_settle_hold: // (R09)
        assert property (st.settleCnt > dpcd_pkg::SETTLE_W'(1) |=> $stable(st.tapPos))
        else $error("tap moved before the settle delay ran out");

    chk_nv_commit: // (R10)
        assert property (clkEn && st.nvBusy && st.nvCnt == dpcd_pkg::NV_CNT_W'(1)
            |=> !st.nvBusy && st.setting[$past(st.nvSel)] == $past(st.nvData))
        else $error("setting write did not land at end of write time");

    chk_powerup_load: // (R15)
        assert property (clkEn && st.state == dpcd_pkg::ST_PWRUP
            |=> st.wiper == $past(st.setting[0]) && st.state == dpcd_pkg::ST_IDLE)
        else $error("wiper not loaded from setting zero at power-up");

endmodule : dpcd_decoder

`default_nettype wire

// ==== testbench/dpcd_bus_master.sv ====
// Two-wire bus master model that frames bytes towards the decoder
`timescale 1ns/1ps
`default_nettype none

module dpcd_bus_master (
    input wire logic clk,      // Bench clock
    input wire logic sdaLine,  // Resolved data wire
    output logic scl,          // Serial clock, idles high between frames
    output logic sdaPull       // Pulls data low while high
);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    // Half a bit is 40 ns, five clocks
    task automatic halfWait();
        repeat (5) @(negedge clk);
    endtask : halfWait

    task automatic startCond();
        sdaPull = 1'b0;
        scl = 1'b1;
        halfWait();
        sdaPull = 1'b1;
        halfWait();
        scl = 1'b0;
    endtask : startCond

    task automatic stopCond();
        sdaPull = 1'b1;
        halfWait();
        scl = 1'b1;
        halfWait();
        sdaPull = 1'b0;
        halfWait();
    endtask : stopCond

    // Data only changes while the clock is low
    task automatic sendBit(input logic b);
        sdaPull = ~b;
        halfWait();
        scl = 1'b1;
        halfWait();
        scl = 1'b0;
    endtask : sendBit

    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(b[i]);
        end
        sdaPull = 1'b0;
        halfWait();
        scl = 1'b1;
        halfWait();
        ack = ~sdaLine;
        scl = 1'b0;
    endtask : sendByte

    // master reads one byte, then acknowledges
    task automatic readByte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sdaPull = 1'b0;
            halfWait();
            scl = 1'b1;
            halfWait();
            b[i] = sdaLine;
            scl = 1'b0;
        end
        sendBit(1'b0);
    endtask : readByte
endmodule : dpcd_bus_master

`default_nettype wire

// ==== testbench/dpcd_decoder_tb_top.sv ====
// Self-checking bench for the potentiometer command decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end

module dpcd_decoder_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic writeProtectN = 1'b1;
    logic [3:0] devSel = 4'h5;
    logic clkEn = 1'b1;
    logic sdaOe, mPull, scl, sdaIn, nvBusy, stepActive, sdaOut;
    logic [5:0] wiperValue;
    logic [63:0] wiperTap;
    int err_count = 0;
    int num_checks = 0;

    // Open-drain wire with pull-up
    assign sdaIn = ~(mPull | sdaOe);

    initial begin
        forever #4 clk = ~clk;
    end

    // Short write time so busy polling fits in the run
    dpcd_decoder #(.NV_WRITE_CYCLES(200)) uut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .sclPin(scl),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtectN(writeProtectN), .deviceSelect(devSel),
        .wiperValue(wiperValue), .wiperTap(wiperTap), .nvBusy(nvBusy), .stepActive(stepActive));

    dpcd_bus_master m (.clk(clk), .sdaLine(sdaIn), .scl(scl), .sdaPull(mPull));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Mode 0 two-byte, 1 write data, 2 read data
    task automatic xfer(input logic [7:0] ins, input int mode, input logic [7:0] wd, output logic [7:0] rd);
        logic a;
        rd = 8'h00;
        m.startCond();
        m.sendByte({dpcd_pkg::TYPE_ID, devSel}, a);
        `CHK(a, 1'b1)
        m.sendByte(ins, a);
        `CHK(a, 1'b1)
        if (mode == 1) begin
            m.sendByte(wd, a);
            `CHK(a, 1'b1)
        end
        if (mode == 2) begin
            m.readByte(rd);
        end
        m.stopCond();
    endtask : xfer

    task automatic settleCheck(input logic [5:0] v);
        repeat (140) @(negedge clk);
        `CHK(wiperValue, v)
        `CHK(wiperTap, 64'h1 << v)
    endtask : settleCheck

    task automatic waitIdle();
        int n;
        n = 0;
        while (nvBusy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            err_count++;
            print_verdict();
        end
    endtask : waitIdle

    task automatic testWiperRw();
        logic [7:0] rd;
        xfer(8'hA0, 1, 8'h15, rd);
        `CHK(wiperValue, 6'h00)
        settleCheck(6'h15);
        xfer(8'h90, 2, 8'h00, rd);
        `CHK(rd, 8'h15)
        $display("Test wiper read/write done");
    endtask : testWiperRw

    task automatic testSettingWrite();
        logic [7:0] rd;
        logic a;
        // Upper data bits must be dropped
        xfer(8'hC8, 1, 8'hEA, rd);
        `CHK(nvBusy, 1'b1)
        m.startCond();
        m.sendByte({dpcd_pkg::TYPE_ID, devSel}, a);
        `CHK(a, 1'b0)
        m.stopCond();
        waitIdle();
        xfer(8'hB8, 2, 8'h00, rd);
        `CHK(rd, 8'h2A)
        writeProtectN = 1'b0;
        xfer(8'hCC, 1, 8'h11, rd);
        waitIdle();
        writeProtectN = 1'b1;
        xfer(8'hBC, 2, 8'h00, rd);
        `CHK(rd, 8'h00)
        $display("Test setting write done");
    endtask : testSettingWrite

    task automatic testTransfers();
        logic [7:0] rd;
        // Filler bits set on purpose
        xfer(8'hE7, 0, 8'h00, rd);
        `CHK(nvBusy, 1'b1)
        waitIdle();
        xfer(8'hB4, 2, 8'h00, rd);
        `CHK(rd, 8'h15)
        xfer(8'hD8, 0, 8'h00, rd);
        `CHK(wiperValue, 6'h15)
        // Clock enable low must freeze the settle count
        clkEn = 1'b0;
        repeat (200) @(negedge clk);
        `CHK(wiperValue, 6'h15)
        clkEn = 1'b1;
        settleCheck(6'h2A);
        $display("Test transfers done");
    endtask : testTransfers

    task automatic testStep();
        logic a;
        m.startCond();
        m.sendByte({dpcd_pkg::TYPE_ID, devSel}, a);
        m.sendByte(8'h20, a);
        `CHK(a, 1'b1)
        // Mode change lands only after the synchronised clock fall
        repeat (4) @(negedge clk);
        `CHK(stepActive, 1'b1)
        // One pulse past the top end
        repeat (22) m.sendBit(1'b1);
        settleCheck(6'h3F);
        repeat (3) m.sendBit(1'b0);
        // The clock rise before stop steps down once more
        m.stopCond();
        `CHK(stepActive, 1'b0)
        settleCheck(6'h3B);
        $display("Test step mode done");
    endtask : testStep

    task automatic testRefused();
        logic a;
        m.startCond();
        m.sendByte({dpcd_pkg::TYPE_ID, ~devSel}, a);
        `CHK(a, 1'b0)
        m.stopCond();
        m.startCond();
        m.sendByte({dpcd_pkg::TYPE_ID, devSel}, a);
        `CHK(a, 1'b1)
        m.sendByte(8'h30, a);
        `CHK(a, 1'b0)
        m.stopCond();
        $display("Test refused frames done");
    endtask : testRefused

    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        `CHK(wiperValue, 6'h00)
        `CHK(wiperTap, 64'h1)
        `CHK(nvBusy, 1'b0)
        `CHK(sdaOut, 1'b0)
        $display("Test reset done");
        testWiperRw();
        testSettingWrite();
        testTransfers();
        testStep();
        testRefused();
        print_verdict();
    end
endmodule : dpcd_decoder_tb_top

`default_nettype wire
